// *** verilog/gptc_timer.v ***
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`include "gptc_consts.vh"
// Operation
// (R1) Timer mode counts cycles, wraps at period
// (R2) Idle with stop bit halts counting
// (R3) Sync counter counts synchronised external edges
// (R4) Async counter counts external edges, wraps
// (R5) Async mode halts in idle if stop
// (R6) Gated mode counts only while gate high
// (R7) Gating needs timer on, internal clock
// (R8) Prescale divides by 1, 8, 64, 256
// (R9) Prescaler clears on count write, off, reset
// (R10) Prescaler frozen while timer disabled
// (R11) Control write leaves count unchanged
// (R12) Interrupt on match and gate fall
// (R13) Sleep counts only on, external, async
// (R14) Match flag set by hardware, software clears
// (R15) Count and period 16-bit read/write
module gptc_timer #(
   parameter CNT_W = 16
) (
   input  wire        core_clk_i,
   input  wire        rst_n_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output reg         pready_o,
   output reg         pslverr_o,
   input  wire        idle_i,
   input  wire        sleep_i,
   input  wire        gate_clock_pin_i,
   output reg         irq_o
);
   // ------------------------------------------------------------
   // Reset release and pin synchronisation
   // ------------------------------------------------------------
   reg  rst_meta_reg;
   reg  rst_sync_reg;
   wire rst_n;
   wire pin_sync;
   wire idle_sync;
   wire sleep_sync;

   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_n = rst_sync_reg;

   gptc_sync2 u_sync_pin (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n),
      .d_i        (gate_clock_pin_i),
      .q_o        (pin_sync)
   );
   gptc_sync2 u_sync_idle (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n),
      .d_i        (idle_i),
      .q_o        (idle_sync)
   );
   gptc_sync2 u_sync_sleep (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n),
      .d_i        (sleep_i),
      .q_o        (sleep_sync)
   );

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg  [CNT_W-1:0]         count_value_reg;
   reg  [CNT_W-1:0]         period_value_reg;
   reg  [15:0]              timer_control_reg;
   reg  [`GPTC_ST_W-1:0]    status_reg;
   reg  [`GPTC_ST_W-1:0]    mask_reg;
   reg                      pin_prev_reg;

   wire timer_on             = timer_control_reg[`GPTC_CTL_ON];
   wire stop_in_idle         = timer_control_reg[`GPTC_CTL_SIDL];
   wire gated_accumulate     = timer_control_reg[`GPTC_CTL_GATE];
   wire clock_source_select  = timer_control_reg[`GPTC_CTL_CS];
   wire external_sync_select = timer_control_reg[`GPTC_CTL_SYNC];
   wire [1:0] prescale_select =
      timer_control_reg[`GPTC_CTL_PS_HI:`GPTC_CTL_PS_LO];

   wire access  = psel_i && penable_i;
   wire wr      = access && pwrite_i;
   wire rd      = access && !pwrite_i;
   wire wr_cnt  = wr && (paddr_i == `GPTC_ADDR_COUNT);
   wire wr_per  = wr && (paddr_i == `GPTC_ADDR_PERIOD);
   wire wr_ctl  = wr && (paddr_i == `GPTC_ADDR_CONTROL);
   wire wr_mask = wr && (paddr_i == `GPTC_ADDR_MASK);
   wire rd_stat = rd && (paddr_i == `GPTC_ADDR_STATUS);
   wire mapped  = (paddr_i == `GPTC_ADDR_COUNT) || (paddr_i == `GPTC_ADDR_PERIOD) ||
                  (paddr_i == `GPTC_ADDR_CONTROL) || (paddr_i == `GPTC_ADDR_STATUS) ||
                  (paddr_i == `GPTC_ADDR_MASK);

   // ------------------------------------------------------------
   // Count source selection
   // ------------------------------------------------------------
   wire pin_rise = pin_sync && !pin_prev_reg;
   wire pin_fall = !pin_sync && pin_prev_reg;
   wire gating   = timer_on && gated_accumulate && !clock_source_select; // (R7)
   // Idle halts every mode when the stop bit is set
   wire idle_hold  = idle_sync && stop_in_idle;                   // (R2) (R5)
   // Sleep only lets the external asynchronous counter run
   wire sleep_hold = sleep_sync &&
                     !(clock_source_select && !external_sync_select); // (R13)
   reg  raw_tick;

   always @* begin
      raw_tick = 1'b0;
      if (clock_source_select) begin
         raw_tick = pin_rise;                                     // (R3) (R4)
      end else if (gated_accumulate) begin
         raw_tick = pin_sync;                                     // (R6)
      end else begin
         raw_tick = 1'b1;                                         // (R1)
      end
   end

   wire run_tick = timer_on && !idle_hold && !sleep_hold && raw_tick; // (R10)
   wire ps_clear = wr_cnt || (wr_ctl && timer_on && !pwdata_i[`GPTC_CTL_ON]); // (R9)
   wire ps_tick;

   gptc_prescaler u_prescaler (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n),
      .tick_i     (run_tick),
      .clear_i    (ps_clear),
      .select_i   (prescale_select),
      .tick_o     (ps_tick)
   );

   // ------------------------------------------------------------
   // Counter
   // ------------------------------------------------------------
   wire at_match = (count_value_reg == period_value_reg);
   wire match_ev = ps_tick && at_match && !wr_cnt;
   wire gate_ev  = gating && pin_fall;                            // (R12)

   always @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         count_value_reg <= `GPTC_COUNT_RESET;
         pin_prev_reg    <= 1'b0;
      end else begin
         pin_prev_reg <= pin_sync;
         if (wr_cnt) begin
            count_value_reg <= pwdata_i[CNT_W-1:0];               // (R11) (R15)
         end else if (ps_tick) begin
            if (at_match) begin
               count_value_reg <= {CNT_W{1'b0}};                  // (R1) (R3) (R4)
            end else begin
               count_value_reg <= count_value_reg + 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Control, period, mask and status
   // ------------------------------------------------------------
   wire [`GPTC_ST_W-1:0] events;
   assign events = {gate_ev, match_ev};

   always @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         period_value_reg  <= `GPTC_PERIOD_RESET;
         timer_control_reg <= `GPTC_CTL_RESET;
         mask_reg          <= {`GPTC_ST_W{1'b0}};
         status_reg        <= {`GPTC_ST_W{1'b0}};
      end else begin
         if (wr_per) begin
            period_value_reg <= pwdata_i[CNT_W-1:0];              // (R15)
         end
         if (wr_ctl) begin
            timer_control_reg <= pwdata_i[15:0] & `GPTC_CTL_WMASK; // (R11)
         end
         if (wr_mask) begin
            mask_reg <= pwdata_i[`GPTC_ST_W-1:0];
         end
         // New events win over the read-clear
         if (rd_stat) begin
            // Clear only the bits this read reported
            status_reg <= (status_reg & ~prdata_o[`GPTC_ST_W-1:0]) | events; // (R14)
         end else begin
            status_reg <= status_reg | events;                    // (R12) (R14)
         end
      end
   end

   // ------------------------------------------------------------
   // APB response and interrupt
   // ------------------------------------------------------------
   reg [31:0] rd_mux;

   always @* begin
      rd_mux = 32'h00000000;
      case (paddr_i)
         `GPTC_ADDR_COUNT:   rd_mux[CNT_W-1:0] = count_value_reg;
         `GPTC_ADDR_PERIOD:  rd_mux[CNT_W-1:0] = period_value_reg;
         `GPTC_ADDR_CONTROL: rd_mux[15:0] = timer_control_reg;
         `GPTC_ADDR_STATUS:  rd_mux[`GPTC_ST_W-1:0] = status_reg;
         `GPTC_ADDR_MASK:    rd_mux[`GPTC_ST_W-1:0] = mask_reg;
         default:            rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         prdata_o  <= 32'h00000000;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         irq_o     <= 1'b0;
      end else begin
         pready_o  <= psel_i && !penable_i;
         pslverr_o <= psel_i && !penable_i && !mapped;
         if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= rd_mux;
         end
         irq_o <= |(status_reg & mask_reg);                       // (R12)
      end
   end
endmodule // gptc_timer

// *** verilog/gptc_consts.vh ***
`ifndef GPTC_CONSTS_VH
`define GPTC_CONSTS_VH
// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define GPTC_ADDR_COUNT     12'h100
`define GPTC_ADDR_PERIOD    12'h104
`define GPTC_ADDR_CONTROL   12'h108
`define GPTC_ADDR_STATUS    12'h10C
`define GPTC_ADDR_MASK      12'h110
`define GPTC_ADDR_W         12
// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define GPTC_CTL_ON         15
`define GPTC_CTL_SIDL       13
`define GPTC_CTL_GATE       6
`define GPTC_CTL_PS_HI      5
`define GPTC_CTL_PS_LO      4
`define GPTC_CTL_SYNC       2
`define GPTC_CTL_CS         1
`define GPTC_CTL_WMASK      16'hA076
`define GPTC_CTL_RESET      16'h0000
`define GPTC_COUNT_RESET    16'h0000
`define GPTC_PERIOD_RESET   16'hFFFF
// ---------------------------------------------------------------
// Status bits
// ---------------------------------------------------------------
`define GPTC_ST_MATCH       0
`define GPTC_ST_GATEFALL    1
`define GPTC_ST_W           2
// ---------------------------------------------------------------
// Prescale select codes and terminal counts
// ---------------------------------------------------------------
`define GPTC_PS_1           2'h0
`define GPTC_PS_8           2'h1
`define GPTC_PS_64          2'h2
`define GPTC_PS_W           8
`define GPTC_PS_T8          8'h07
`define GPTC_PS_T64         8'h3F
`define GPTC_PS_T256        8'hFF
`endif

// *** verilog/gptc_sync2.v ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Two-flop level synchroniser
// ---------------------------------------------------------------
module gptc_sync2 (
   input  wire core_clk_i,
   input  wire rst_n_i,
   input  wire d_i,
   output wire q_o
);
   reg meta_reg;
   reg sync_reg;

   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end

   assign q_o = sync_reg;
endmodule // gptc_sync2

// *** verilog/gptc_prescaler.v ***
`timescale 1ns/1ps
`include "gptc_consts.vh"
// ---------------------------------------------------------------
// Prescaler: divides count enables by 1, 8, 64 or 256
// ---------------------------------------------------------------
module gptc_prescaler (
   input  wire       core_clk_i,
   input  wire       rst_n_i,
   input  wire       tick_i,
   input  wire       clear_i,
   input  wire [1:0] select_i,
   output wire       tick_o
);
   reg  [`GPTC_PS_W-1:0] count_reg;
   reg  [`GPTC_PS_W-1:0] terminal;

   always @* begin
      case (select_i)
         `GPTC_PS_1:  terminal = {`GPTC_PS_W{1'b0}};
         `GPTC_PS_8:  terminal = `GPTC_PS_T8;
         `GPTC_PS_64: terminal = `GPTC_PS_T64;
         default:     terminal = `GPTC_PS_T256;
      endcase
   end

   assign tick_o = tick_i && (count_reg >= terminal); // (R8)

   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_reg <= {`GPTC_PS_W{1'b0}}; // (R9)
      end else if (clear_i) begin
         count_reg <= {`GPTC_PS_W{1'b0}}; // (R9)
      end else if (tick_i) begin
         if (count_reg >= terminal) begin
            count_reg <= {`GPTC_PS_W{1'b0}};
         end else begin
            count_reg <= count_reg + 1'b1;
         end
      end
   end
endmodule // gptc_prescaler

// *** verification/gptc_timer_properties.sv ***
`timescale 1ns/1ps
`include "gptc_consts.vh"
module gptc_timer_properties #(
   parameter CNT_W = 16
) (
   input wire        core_clk_i,
   input wire        rst_n_i,
   input wire        psel_i,
   input wire        penable_i,
   input wire        pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [31:0] prdata_o,
   input wire        pready_o,
   input wire        pslverr_o,
   input wire        idle_i,
   input wire        sleep_i,
   input wire        gate_clock_pin_i,
   input wire        irq_o
);
   wire rd_done = pready_o && !pwrite_i;
   wire mapped  = paddr_i == `GPTC_ADDR_COUNT || paddr_i == `GPTC_ADDR_PERIOD ||
                  paddr_i == `GPTC_ADDR_CONTROL || paddr_i == `GPTC_ADDR_STATUS ||
                  paddr_i == `GPTC_ADDR_MASK;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
      else $error("ready outside access");
   a_err_unmapped: assert property (pready_o && !mapped |-> pslverr_o)
      else $error("unmapped access not refused");
   a_no_err_mapped: assert property (pready_o && mapped |-> !pslverr_o)
      else $error("mapped access refused");
   a_err_with_ready: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   a_err_reads_zero: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
      else $error("refused read not zero");
   a_upper_zero: assert property (rd_done |-> prdata_o[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   a_ctl_fields_only: assert property (rd_done && paddr_i == `GPTC_ADDR_CONTROL
      |-> (prdata_o[15:0] & ~`GPTC_CTL_WMASK) == 16'h0000)
      else $error("reserved control bits set");
   a_status_width: assert property (rd_done && (paddr_i == `GPTC_ADDR_STATUS ||
      paddr_i == `GPTC_ADDR_MASK) |-> prdata_o[31:2] == 30'h0)
      else $error("status or mask too wide");
   c_refused: cover property (pslverr_o);
   c_irq: cover property (irq_o);
   c_match_read: cover property (rd_done && paddr_i == `GPTC_ADDR_STATUS && prdata_o[0]);
endmodule // gptc_timer_properties

bind gptc_timer gptc_timer_properties #(.CNT_W(CNT_W)) u_gptc_timer_properties (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .idle_i(idle_i), .sleep_i(sleep_i),
   .gate_clock_pin_i(gate_clock_pin_i), .irq_o(irq_o));

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`include "gptc_consts.vh"
module testbench;
   reg         core_clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   reg  [11:0] paddr_i = 12'h000;
   reg  [31:0] pwdata_i = 32'h0;
   reg         idle_i = 0, sleep_i = 0, gate_clock_pin_i = 0;
   wire [31:0] prdata_o;
   wire        pready_o, pslverr_o, irq_o;
   integer     failures = 0, n_compared = 0, i, k;
   reg  [31:0] rd_data;
   reg         rd_err;
   gptc_timer #(.CNT_W(16)) u_gptc_timer (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .idle_i(idle_i), .sleep_i(sleep_i),
      .gate_clock_pin_i(gate_clock_pin_i), .irq_o(irq_o));
   initial begin
      forever #20 core_clk_i = ~core_clk_i;
   end
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge core_clk_i);
         psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
         @(posedge core_clk_i);
         penable_i <= 1;
         k = 0;
         @(posedge core_clk_i);
         while (pready_o !== 1'b1 && k < 50) begin
            @(posedge core_clk_i);
            k = k + 1;
         end
         if (k == 50) failures = failures + 1;
         rd_data = prdata_o;
         rd_err = pslverr_o;
         psel_i <= 0; penable_i <= 0;
      end
   endtask
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         n_compared = n_compared + 1;
         if (g !== e) begin
            failures = failures + 1;
            $display("unexpected %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task rng(input string nm, input [31:0] lo, input [31:0] hi, input [31:0] g);
      begin
         n_compared = n_compared + 1;
         if (^g === 1'bx || !(g >= lo && g <= hi)) begin
            failures = failures + 1;
            $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, g);
         end
      end
   endtask
   task ext(input [31:0] ctl, input idl, input slp, input [31:0] exp);
      begin
         idle_i <= idl; sleep_i <= slp;
         apb(1, `GPTC_ADDR_CONTROL, 0); apb(1, `GPTC_ADDR_COUNT, 0);
         apb(1, `GPTC_ADDR_CONTROL, ctl);
         repeat (5) begin
            gate_clock_pin_i <= 1; repeat (4) @(posedge core_clk_i);
            gate_clock_pin_i <= 0; repeat (4) @(posedge core_clk_i);
         end
         repeat (6) @(posedge core_clk_i);
         apb(0, `GPTC_ADDR_COUNT, 0);
         chk("external count", exp, rd_data);
      end
   endtask
   task gated(input [31:0] ctl, input [31:0] lo, input [31:0] hi, input [31:0] fall);
      begin
         apb(1, `GPTC_ADDR_COUNT, 0); apb(1, `GPTC_ADDR_CONTROL, ctl);
         apb(0, `GPTC_ADDR_STATUS, 0);
         gate_clock_pin_i <= 1; repeat (20) @(posedge core_clk_i);
         gate_clock_pin_i <= 0; repeat (10) @(posedge core_clk_i);
         apb(0, `GPTC_ADDR_COUNT, 0); rng("gated count", lo, hi, rd_data);
         apb(0, `GPTC_ADDR_STATUS, 0); chk("gate fall", fall, rd_data[1]);
         apb(1, `GPTC_ADDR_CONTROL, 0);
      end
   endtask
   task print_verdict;
      begin
         $display("compared %0d failures %0d", n_compared, failures);
         if (failures == 0 && n_compared > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   initial begin
      #(40 * 40000);
      failures = failures + 1;
      print_verdict;
   end
   initial begin
      repeat (5) @(posedge core_clk_i);
      rst_n_i <= 1;
      repeat (3) @(posedge core_clk_i);
      apb(0, `GPTC_ADDR_COUNT, 0); chk("count reset", 0, rd_data);
      apb(0, `GPTC_ADDR_PERIOD, 0); chk("period reset", 32'hFFFF, rd_data);
      apb(0, `GPTC_ADDR_CONTROL, 0); chk("control reset", 0, rd_data);
      apb(0, 12'h200, 0); chk("unmapped err", 1, rd_err);
      apb(1, `GPTC_ADDR_COUNT, 32'h1234); apb(1, `GPTC_ADDR_CONTROL, 32'h0010);
      apb(0, `GPTC_ADDR_COUNT, 0); chk("count kept", 32'h1234, rd_data);
      $display("test registers done");
      for (i = 0; i < 4; i = i + 1) begin
         apb(1, `GPTC_ADDR_CONTROL, 0); apb(1, `GPTC_ADDR_COUNT, 0);
         apb(1, `GPTC_ADDR_CONTROL, 32'h8000 | (i << 4));
         repeat (8 * ((i == 3) ? 256 : (1 << (3 * i))) - 3) @(posedge core_clk_i);
         apb(1, `GPTC_ADDR_CONTROL, 0);
         apb(0, `GPTC_ADDR_COUNT, 0); chk("prescaled count", 8, rd_data);
      end
      repeat (20) @(posedge core_clk_i);
      apb(0, `GPTC_ADDR_COUNT, 0); chk("count frozen", 8, rd_data);
      apb(1, `GPTC_ADDR_COUNT, 0); apb(1, `GPTC_ADDR_CONTROL, 32'h8030);
      repeat (200) @(posedge core_clk_i);
      apb(1, `GPTC_ADDR_COUNT, 0);
      repeat (200) @(posedge core_clk_i);
      apb(0, `GPTC_ADDR_COUNT, 0); chk("prescaler cleared", 0, rd_data);
      $display("test prescaler done");
      apb(1, `GPTC_ADDR_CONTROL, 0); apb(1, `GPTC_ADDR_PERIOD, 4);
      apb(1, `GPTC_ADDR_MASK, 1); apb(1, `GPTC_ADDR_COUNT, 0);
      apb(1, `GPTC_ADDR_CONTROL, 32'h8000);
      repeat (8) begin
         apb(0, `GPTC_ADDR_COUNT, 0); rng("wrapped count", 0, 4, rd_data);
      end
      chk("irq raised", 1, irq_o);
      apb(1, `GPTC_ADDR_CONTROL, 0); apb(1, `GPTC_ADDR_MASK, 0);
      repeat (3) @(posedge core_clk_i);
      chk("irq masked", 0, irq_o);
      apb(1, `GPTC_ADDR_MASK, 3);
      repeat (3) @(posedge core_clk_i);
      chk("irq unmasked", 1, irq_o);
      apb(0, `GPTC_ADDR_STATUS, 0); chk("match flag", 1, rd_data[0]);
      repeat (3) @(posedge core_clk_i);
      chk("irq cleared", 0, irq_o);
      apb(0, `GPTC_ADDR_STATUS, 0); chk("status cleared", 0, rd_data);
      $display("test interrupt done");
      apb(1, `GPTC_ADDR_PERIOD, 32'hFFFF);
      gated(32'h8040, 18, 22, 1);
      gated(32'h8042, 1, 1, 0);
      ext(32'h8006, 0, 0, 5);
      ext(32'h8002, 0, 0, 5);
      ext(32'hA002, 1, 0, 0);
      ext(32'h8002, 1, 0, 5);
      ext(32'hA006, 1, 0, 0);
      ext(32'hA000, 1, 0, 0);
      ext(32'h8002, 0, 1, 5);
      ext(32'h8006, 0, 1, 0);
      ext(32'h8000, 0, 1, 0);
      $display("test modes done");
      print_verdict;
   end
endmodule // testbench
